// ---- vsl_frame_src.sv ----
// Purpose: Display frame sync source
// Assumes: Sync to pclk
// Notes:   One pclk pulse per frame
`timescale 1ns/1ps
module vsl_frame_src #(parameter int GAP = 40) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      frame_sync
);
	logic [12:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q      <= 13'h0000;
			frame_sync <= 1'b0;
		end else begin
			cnt_q      <= (run && cnt_q != 13'(GAP - 1)) ? cnt_q + 13'h0001 : 13'h0000;
			frame_sync <= run && cnt_q == 13'(GAP - 1);
		end
	end
endmodule // vsl_frame_src

// ---- vsl_period_gen.sv ----
// Purpose: PWM period tick generator, free running or locked to frame sync
// Assumes: frame_sync and loop_tick are synchronous one-cycle strobes
// Notes:   A limit of zero acts as one so the tick never stalls
`timescale 1ns/1ps
module vsl_period_gen (
	input  wire logic pclk,
	input  wire logic presetn,
	vsl_tick_if.gen   tk
);
	logic [12:0] cnt_q;
	logic [12:0] limit;
	logic        tick_q;

	// Divider count only matters while locked; otherwise the free period rules
	assign limit = tk.lock_en ? tk.sync_div : {5'h00, tk.free_period}; // R3

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 13'h0000;
			tick_q <= 1'b0;
		end else if (tk.lock_en && tk.frame_sync) begin
			cnt_q  <= 13'h0000; // R3
			tick_q <= 1'b1;
		end else if (tk.loop_tick && ((cnt_q + 13'h0001) >= limit)) begin
			cnt_q  <= 13'h0000;
			tick_q <= 1'b1;
		end else if (tk.loop_tick) begin
			cnt_q  <= cnt_q + 13'h0001;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
		end
	end

	assign tk.period_tick = tick_q;
endmodule // vsl_period_gen

// ---- vsl_pkg.sv ----
// Purpose: Shared constants for the frame-sync-locked PWM configuration block
// Assumes: 40 MHz pclk, APB register access with 32-bit data
// Notes:   Register offsets are word indexes; byte address is four times the index
package vsl_pkg;
	localparam logic [7:0]  IDX_DIV_HIGH   = 8'hA6;
	localparam logic [7:0]  IDX_DIV_LOW    = 8'hA7;
	localparam logic [11:0] ADDR_DIV_HIGH  = {2'h0, IDX_DIV_HIGH, 2'h0};
	localparam logic [11:0] ADDR_DIV_LOW   = {2'h0, IDX_DIV_LOW, 2'h0};
	localparam logic [11:0] ADDR_CTRL      = 12'h000;
	localparam logic [11:0] ADDR_STATUS    = 12'h004;
	// Divider low byte layout
	localparam int          LOW_DIV_LSB    = 3;
	localparam int          LOW_FRES_BIT   = 2;
	localparam int          LOW_HYST_LSB   = 0;
	// Control register layout
	localparam int          CTRL_LOCK_BIT  = 0;
	localparam int          CTRL_RES_LSB   = 1;
	localparam int          CTRL_FREQ_LSB  = 8;
	// Status register layout
	localparam int          STAT_FRES_BIT  = 0;
	localparam int          STAT_LOCK_BIT  = 1;
	localparam int          STAT_DUTY_LSB  = 16;
	// Reset values
	localparam logic [7:0]  RST_DIV_HIGH   = 8'h00;
	localparam logic [7:0]  RST_DIV_LOW    = 8'h00;
	localparam logic [15:0] RST_CTRL       = 16'h0000;
	// Loop rate: pclk divide ratio per resolution code (40 MHz / 8,4,2,1 = 5,10,20,40 MHz)
	localparam int          PCLK_MHZ       = 40;
	localparam int          LOOP_MHZ_0     = 5;
	localparam int          LOOP_MHZ_1     = 10;
	localparam int          LOOP_MHZ_2     = 20;
	localparam int          LOOP_MHZ_3     = 40;
	localparam logic [3:0]  LOOP_DIV_0     = 4'(PCLK_MHZ / LOOP_MHZ_0);
	localparam logic [3:0]  LOOP_DIV_1     = 4'(PCLK_MHZ / LOOP_MHZ_1);
	localparam logic [3:0]  LOOP_DIV_2     = 4'(PCLK_MHZ / LOOP_MHZ_2);
	localparam logic [3:0]  LOOP_DIV_3     = 4'(PCLK_MHZ / LOOP_MHZ_3);
	// Hysteresis dead band in 11-bit input LSBs for codes 01, 10, 11
	localparam logic [10:0] HYST_STEP_11B  = 11'h001;
	localparam logic [10:0] HYST_STEP_10B  = 11'h002;
	localparam logic [10:0] HYST_STEP_8B   = 11'h008;

	typedef enum logic [1:0] {
		VSL_HYST_OFF = 2'b00,
		VSL_HYST_11B = 2'b01,
		VSL_HYST_10B = 2'b10,
		VSL_HYST_8B  = 2'b11
	} vsl_hyst_t;
endpackage

// ---- vsl_sync_pwm_cfg.sv ----
// Purpose: Frame-sync-locked PWM timing configuration with APB registers
// Assumes: 40 MHz pclk; frame_sync, duty inputs synchronous to pclk
// Notes:   One wait state on every APB access
//
// How it works
// R1: Divider count bits 12..5 fill all of the high divider byte.
// R2: Divider count bits 4..0 sit in bits 7..3 of the low byte.
// R3: Divider count used only while frame-sync lock is on, else ignored.
// R4: Resistor enable bit 2 picks resistor or register field for PWM frequency.
// R5: Hysteresis bits 1:0 filter small input duty changes at 11, 10, 8 bits.
// R6: Programmer sets count to loop rate over N times frame rate.
// R7: Loop rate 5, 10, 20 or 40 MHz chosen by resolution field.
// R8: Programmer rounds the formula result to a whole unsigned 13-bit value.
`timescale 1ns/1ps
module vsl_sync_pwm_cfg (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frame_sync,
	input  wire logic [7:0]  freq_set_resistor,
	input  wire logic [10:0] duty_in,
	input  wire logic        duty_valid,
	output logic      [10:0] duty_out,
	output logic             period_tick,
	output logic             loop_tick
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0]  div_high_q;
	logic [7:0]  div_low_q;
	logic [15:0] ctrl_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [3:0]  loop_cnt_q;
	logic        loop_tick_q;
	logic [10:0] duty_q;
	logic        locked_q;
	logic        period_q;
	logic [3:0]  loop_div;
	logic [10:0] step;
	logic [10:0] diff;
	logic        access;
	logic        wr_en;
	logic        rd_en;
	logic        sel_high;
	logic        sel_low;
	logic        sel_ctrl;
	logic        hit;
	logic [31:0] rd_val;
	vsl_tick_if  tk ();

	////////////////////////////////////////////////////////////////////////////
	// APB: answer in the second access cycle so read data comes from a flop
	assign access   = psel && penable && !pready_q;
	assign rd_en    = access && !pwrite;
	// Writes land on the edge that completes the transfer, never earlier
	assign wr_en    = psel && penable && pready_q && pwrite;
	assign sel_high = (paddr == vsl_pkg::ADDR_DIV_HIGH);
	assign sel_low  = (paddr == vsl_pkg::ADDR_DIV_LOW);
	assign sel_ctrl = (paddr == vsl_pkg::ADDR_CTRL);

	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			vsl_pkg::ADDR_DIV_HIGH: rd_val = {24'h00_0000, div_high_q};
			vsl_pkg::ADDR_DIV_LOW:  rd_val = {24'h00_0000, div_low_q};
			vsl_pkg::ADDR_CTRL:     rd_val = {16'h0000, ctrl_q};
			vsl_pkg::ADDR_STATUS: begin
				rd_val[vsl_pkg::STAT_FRES_BIT] = div_low_q[vsl_pkg::LOW_FRES_BIT];
				rd_val[vsl_pkg::STAT_LOCK_BIT] = locked_q;
				rd_val[vsl_pkg::STAT_DUTY_LSB +: 11] = duty_q;
			end
			default:                hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= access && !hit;
		end
	end

	// Read data is captured once, so it stands until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata_q <= rd_val;
		end
	end

	// Registers; the status word is read-only and writes to it are ignored without an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_high_q <= vsl_pkg::RST_DIV_HIGH;
		end else if (wr_en && sel_high) begin
			div_high_q <= pwdata[7:0]; // R1
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_low_q <= vsl_pkg::RST_DIV_LOW;
		end else if (wr_en && sel_low) begin
			div_low_q <= pwdata[7:0]; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= vsl_pkg::RST_CTRL;
		end else if (wr_en && sel_ctrl) begin
			ctrl_q <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Loop rate enable; a resolution change does not restart the divider
	// Limitation: the loop period around a resolution change may be short once
	always_comb begin
		case (ctrl_q[vsl_pkg::CTRL_RES_LSB +: 2])
			2'b00:   loop_div = vsl_pkg::LOOP_DIV_0; // R7
			2'b01:   loop_div = vsl_pkg::LOOP_DIV_1; // R7
			2'b10:   loop_div = vsl_pkg::LOOP_DIV_2; // R7
			default: loop_div = vsl_pkg::LOOP_DIV_3; // R7
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_cnt_q  <= 4'h0;
			loop_tick_q <= 1'b0;
		end else if ((loop_cnt_q + 4'h1) >= loop_div) begin
			loop_cnt_q  <= 4'h0; // R7
			loop_tick_q <= 1'b1;
		end else begin
			loop_cnt_q  <= loop_cnt_q + 4'h1;
			loop_tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Period generator hookup
	assign tk.loop_tick   = loop_tick_q;
	assign tk.lock_en     = ctrl_q[vsl_pkg::CTRL_LOCK_BIT]; // R3
	assign tk.frame_sync  = frame_sync;
	assign tk.sync_div    = {div_high_q, div_low_q[vsl_pkg::LOW_DIV_LSB +: 5]}; // R1 R2
	// Resistor code replaces the register field only when enabled
	assign tk.free_period = div_low_q[vsl_pkg::LOW_FRES_BIT] ? freq_set_resistor
		: ctrl_q[vsl_pkg::CTRL_FREQ_LSB +: 8]; // R4

	vsl_period_gen vsl_period_gen_i (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk)
	);

	// Period tick passes one more flop so the output comes straight from a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q <= 1'b0;
		end else begin
			period_q <= tk.period_tick;
		end
	end

	// Lock seen: set by a frame sync while locking; cleared when locking is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked_q <= 1'b0;
		end else if (!tk.lock_en) begin
			locked_q <= 1'b0; // R3
		end else if (frame_sync) begin
			locked_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input hysteresis: a change within the dead band is held back to stop flicker
	// Code 00 leaves the band at zero so every new duty passes
	always_comb begin
		case (vsl_pkg::vsl_hyst_t'(div_low_q[vsl_pkg::LOW_HYST_LSB +: 2]))
			vsl_pkg::VSL_HYST_11B: step = vsl_pkg::HYST_STEP_11B; // R5
			vsl_pkg::VSL_HYST_10B: step = vsl_pkg::HYST_STEP_10B; // R5
			vsl_pkg::VSL_HYST_8B:  step = vsl_pkg::HYST_STEP_8B; // R5
			default:               step = 11'h000;
		endcase
		diff = (duty_in >= duty_q) ? (duty_in - duty_q) : (duty_q - duty_in);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_q <= 11'h000;
		end else if (duty_valid && (diff > step)) begin
			duty_q <= duty_in; // R5
		end
	end

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign duty_out    = duty_q;
	assign period_tick = period_q;
	assign loop_tick   = loop_tick_q;
endmodule // vsl_sync_pwm_cfg

// ---- vsl_sync_pwm_cfg_properties.sv ----
// Purpose: Port properties of the sync PWM config block
// Assumes: One pclk domain
// Notes:   Sees only top ports
`timescale 1ns/1ps
module vsl_sync_pwm_cfg_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [10:0] duty_in,
	input wire logic        duty_valid,
	input wire logic [10:0] duty_out,
	input wire logic        loop_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_due; psel && penable && !pready |=> pready; endproperty
	a_due: assert property (p_due) else $error("pready late");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr alone");
	property p_cause; pready |-> $past(psel) && $past(penable); endproperty
	a_cause: assert property (p_cause) else $error("pready unasked");
	property p_dset; duty_out != $past(duty_out) |-> $past(duty_valid); endproperty
	a_dset: assert property (p_dset) else $error("duty moved alone");
	// Step of 8 is the widest band, so larger jumps always pass
	property p_dbig; duty_valid && ({1'b0, duty_in} > duty_out + 12'h008 || {1'b0, duty_out} > duty_in + 12'h008)
		|=> duty_out == $past(duty_in); endproperty
	a_dbig: assert property (p_dbig) else $error("duty jump lost");
	property p_dsame; duty_valid && duty_in == duty_out |=> $stable(duty_out); endproperty
	a_dsame: assert property (p_dsame) else $error("duty drift");
	property p_loop; loop_tick |-> ##[1:8] loop_tick; endproperty
	a_loop: assert property (p_loop) else $error("loop tick gap");
endmodule // vsl_sync_pwm_cfg_properties
bind vsl_sync_pwm_cfg vsl_sync_pwm_cfg_properties vsl_sync_pwm_cfg_properties_i (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .duty_in, .duty_valid, .duty_out, .loop_tick);

// ---- vsl_sync_pwm_cfg_test.sv ----
// Purpose: Self-checking bench for the sync PWM config block
// Assumes: 40 MHz pclk
// Notes:   Bus answers checked by a queue monitor
`timescale 1ns/1ps
module vsl_sync_pwm_cfg_test;
	localparam logic [11:0] HI = vsl_pkg::ADDR_DIV_HIGH;
	localparam logic [11:0] LO = vsl_pkg::ADDR_DIV_LOW;
	localparam logic [11:0] CT = vsl_pkg::ADDR_CTRL;
	localparam logic [11:0] ST = vsl_pkg::ADDR_STATUS;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_sync, run;
	logic        duty_valid, period_tick, loop_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  freq_set_resistor;
	logic [10:0] duty_in, duty_out;
	logic [33:0] q[$];
	logic [33:0] nt;
	int          err_total, tests_run, cyc, dexp, base;
	int          st[4] = '{0, 1, 2, 8};
	vsl_sync_pwm_cfg vsl_sync_pwm_cfg_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .frame_sync, .freq_set_resistor, .duty_in, .duty_valid, .duty_out, .period_tick, .loop_tick);
	vsl_frame_src #(.GAP(196 * 33)) vsl_frame_src_i (.pclk, .presetn, .run, .frame_sync);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Idles one cycle after release so psel is never driven twice in a step
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic r);
		q.push_back({w, e, r});
		{paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic gap(input bit s, input int e);
		int n;
		n = 0;
		repeat (2) do @(posedge pclk); while ((s ? loop_tick : period_tick) !== 1'b1);
		do begin
			@(posedge pclk);
			n++;
		end while ((s ? loop_tick : period_tick) !== 1'b1);
		cmp(32'(n), 32'(e));
	endtask
	task automatic sync_chk(input logic e);
		do @(posedge pclk); while (frame_sync !== 1'b1);
		repeat (2) @(posedge pclk);
		cmp({31'h0, period_tick}, {31'h0, e});
	endtask
	task automatic dut(input int v, input int s);
		{duty_in, duty_valid} <= {11'(v), 1'b1};
		@(posedge pclk);
		duty_valid <= 1'b0;
		if (v > dexp + s || dexp > v + s) dexp = v;
		@(posedge pclk);
		cmp(32'(duty_out), 32'(dexp));
	endtask
	task automatic give_verdict();
		$display("Checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		if (pready === 1'b1 && q.size() > 0) begin
			nt = q.pop_front();
			if (!nt[33]) cmp(prdata, nt[32:1]);
			cmp({31'h0, pslverr}, {31'h0, nt[0]});
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, run, duty_valid, paddr, pwdata, freq_set_resistor, duty_in} = '0;
		dexp = 0;
		void'($urandom(60));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(0, HI, 0, 0, 0);
		bus(0, LO, 0, 0, 0);
		base = $urandom;
		bus(1, HI, base, 0, 0);
		bus(0, HI, 0, base & 255, 0);
		bus(1, LO, base >> 8, 0, 0);
		bus(0, LO, 0, (base >> 8) & 255, 0);
		bus(1, 12'h100, 32'hFF, 0, 1);
		bus(0, 12'h100, 0, 0, 1);
		$display("test registers done");
		for (int r = 0; r < 4; r++) begin
			bus(1, CT, r << 1, 0, 0);
			gap(1, 8 >> r);
		end
		$display("test loop rate done");
		freq_set_resistor <= 8'h06;
		bus(1, CT, 32'h0A06, 0, 0);
		bus(1, LO, 32'h04, 0, 0);
		gap(0, 6);
		bus(0, ST, 0, 32'h1, 0);
		bus(1, LO, 32'h08, 0, 0);
		gap(0, 10);
		$display("test frequency source done");
		bus(1, HI, 32'h01, 0, 0);
		bus(1, CT, 32'h0A07, 0, 0);
		gap(0, 33);
		run <= 1'b1;
		sync_chk(1);
		bus(0, ST, 0, 32'h2, 0);
		bus(1, CT, 32'hFF00, 0, 0);
		sync_chk(0);
		bus(0, ST, 0, 32'h0, 0);
		$display("test frame lock done");
		for (int h = 0; h < 4; h++) begin
			bus(1, LO, h, 0, 0);
			base = 256 * (h + 1) + ($urandom & 127);
			dut(base, st[h]);
			dut(base + st[h], st[h]);
			dut(base + st[h] + 1, st[h]);
		end
		$display("test hysteresis done");
		give_verdict();
	end
endmodule // vsl_sync_pwm_cfg_test

// ---- vsl_tick_if.sv ----
// Purpose: Carrier between configuration logic and the period generator
// Assumes: Single pclk domain
// Notes:   Strobes are one pclk wide
`timescale 1ns/1ps
interface vsl_tick_if;
	logic        loop_tick;
	logic        lock_en;
	logic        frame_sync;
	logic [12:0] sync_div;
	logic [7:0]  free_period;
	logic        period_tick;

	modport ctl (output loop_tick, output lock_en, output frame_sync, output sync_div,
		output free_period, input period_tick);
	modport gen (input loop_tick, input lock_en, input frame_sync, input sync_div,
		input free_period, output period_tick);
endinterface
